// [common/vram_defines.svh]
`ifndef VRAM_DEFINES_SVH
`define VRAM_DEFINES_SVH

// ****************************************
// Register offsets
// ****************************************
`define VRAM_OFS_CUR_VOL 8'h4D
`define VRAM_OFS_NORMAL 8'h4E
`define VRAM_OFS_EMERG 8'h4F
`define VRAM_OFS_AM_CTRL 8'h50
`define VRAM_OFS_AM_TIME 8'h51
`define VRAM_OFS_STATUS 8'h52

// ****************************************
// Reset values
// ****************************************
`define VRAM_RST_NORMAL 8'h33
`define VRAM_RST_EMERG 8'h30
`define VRAM_RST_AM_CTRL 8'h07
`define VRAM_RST_AM_TIME 8'h00
`define VRAM_VOL_0DB 8'h30
`define VRAM_VOL_MUTE 8'hFF

// ****************************************
// Field positions
// ****************************************
`define VRAM_FALL_IVL 7:6
`define VRAM_FALL_STEP 5:4
`define VRAM_RISE_IVL 3:2
`define VRAM_RISE_STEP 1:0
`define VRAM_AM_JOINT 2
`define VRAM_AM_EN_RIGHT 1
`define VRAM_AM_EN_LEFT 0
`define VRAM_SIL_LEFT 6:4
`define VRAM_SIL_RIGHT 2:0
`define VRAM_IVL_INSTANT 2'h3

// ****************************************
// Silence lengths in microseconds at the reference rate
// ****************************************
`define VRAM_REF_RATE_KHZ 96
`define VRAM_SIL_T0_US 11500
`define VRAM_SIL_T1_US 53000
`define VRAM_SIL_T2_US 106500
`define VRAM_SIL_T3_US 266500
`define VRAM_SIL_T4_US 535000
`define VRAM_SIL_T5_US 1065000
`define VRAM_SIL_T6_US 2665000
`define VRAM_SIL_T7_US 5330000
`define VRAM_SIL_CNT_W 19

`endif

// [common/vram_pkg.sv]
package vram_pkg;

	typedef struct packed {
		logic [23:0] left;
		logic [23:0] right;
	} vram_pair_t;

	typedef struct packed {
		logic [7:0] volume;
		logic mute_left;
		logic mute_right;
		vram_pair_t pair;
	} vram_out_t;

	typedef enum logic [3:0] {
		VRAM_IDLE = 4'h1,
		VRAM_RISE = 4'h2,
		VRAM_FALL = 4'h4,
		VRAM_EMERG = 4'h8
	} vram_state_t;

endpackage : vram_pkg

// [rtl/vram_top.sv]
// What this block does
// - Volume code: 0x30 is 0 dB, 0xFF mute.
// - Normal fall updates every 1, 2, 4 samples.
// - Fall interval code 11 jumps to the target level instantly.
// - Fall step 4, 2, 1, 0.5 dB.
// - Rise updates every 1, 2, 4 samples.
// - Rise interval code 11 restores instantly.
// - Rise step 4, 2, 1, 0.5 dB.
// - Clock error or outage uses emergency interval.
// - Emergency fall uses emergency step size.
// - Joint policy mutes only when both qualify.
// - Right enable bit gates right auto-mute.
// - Left enable bit gates left auto-mute.
// - Left mutes after left silence length.
// - Right mutes after right silence length.
// - Silence codes map to fixed sample counts.
`timescale 1ns/1ps
`include "vram_defines.svh"
`default_nettype none

// ****************************************
// Sample FIFO
// ****************************************
module vram_fifo #(
	parameter int WIDTH = 48,
	parameter int DEPTH = 8
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic [AW:0] next_count;
	logic push;
	logic pop;

	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rd_ptr];

	always_comb begin
		next_count = count;
		if (push && !pop) begin
			next_count = count + 1'b1;
		end else if (pop && !push) begin
			next_count = count - 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			count <= '0;
			in_ready <= 1'b0;
			out_valid <= 1'b0;
		end else begin
			count <= next_count;
			// Flags are registered so the ready seen upstream is a clean flop output.
			in_ready <= (next_count != (AW+1)'(DEPTH));
			out_valid <= (next_count != '0);
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end
endmodule : vram_fifo

// ****************************************
// Volume ramp and auto-mute
// ****************************************
module vram_top
	import vram_pkg::*;
#(
	parameter int FIFO_DEPTH = 8,
	parameter int SILENCE_DIV = 1
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic [7:0] target_volume_level,
	input wire logic clock_error,
	input wire logic power_outage,
	input wire logic reg_wr_en,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic sample_valid,
	output logic sample_ready,
	input wire vram_pair_t sample_in,
	output logic out_valid,
	input wire logic out_ready,
	output vram_out_t out_word,
	output logic [7:0] current_volume,
	output logic mute_left,
	output logic mute_right
);
	localparam int PW = $bits(vram_pair_t);

	// Sample count for a silence code; the counts are fixed, so time scales with rate.
	function automatic logic [`VRAM_SIL_CNT_W-1:0] sil_len(input logic [2:0] code);
		int us;
		us = `VRAM_SIL_T0_US;
		case (code)
			3'h0: us = `VRAM_SIL_T0_US;
			3'h1: us = `VRAM_SIL_T1_US;
			3'h2: us = `VRAM_SIL_T2_US;
			3'h3: us = `VRAM_SIL_T3_US;
			3'h4: us = `VRAM_SIL_T4_US;
			3'h5: us = `VRAM_SIL_T5_US;
			3'h6: us = `VRAM_SIL_T6_US;
			default: us = `VRAM_SIL_T7_US;
		endcase
		sil_len = `VRAM_SIL_CNT_W'((us / 1000 * `VRAM_REF_RATE_KHZ
			+ (us % 1000) * `VRAM_REF_RATE_KHZ / 1000) / SILENCE_DIV);
	endfunction : sil_len

	// Last value of the sample divider for an interval code.
	function automatic logic [1:0] ivl_last(input logic [1:0] code);
		case (code)
			2'h0: ivl_last = 2'h0;
			2'h1: ivl_last = 2'h1;
			default: ivl_last = 2'h3;
		endcase
	endfunction : ivl_last

	// One volume code is half a decibel.
	function automatic logic [7:0] step_codes(input logic [1:0] code);
		case (code)
			2'h0: step_codes = 8'h08;
			2'h1: step_codes = 8'h04;
			2'h2: step_codes = 8'h02;
			default: step_codes = 8'h01;
		endcase
	endfunction : step_codes

	// ****************************************
	// Registers
	// ****************************************
	logic [7:0] normal_ramp_control;
	logic [7:0] emergency_ramp_control;
	logic [7:0] auto_mute_control;
	logic [7:0] auto_mute_time;
	logic [7:0] cur_vol;
	logic [1:0] muted;
	vram_state_t state;
	vram_state_t next_state;

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			normal_ramp_control <= `VRAM_RST_NORMAL;
			emergency_ramp_control <= `VRAM_RST_EMERG;
			auto_mute_control <= `VRAM_RST_AM_CTRL;
			auto_mute_time <= `VRAM_RST_AM_TIME;
		end else if (reg_wr_en) begin
			case (reg_addr)
				`VRAM_OFS_NORMAL: normal_ramp_control <= reg_wdata;
				`VRAM_OFS_EMERG: emergency_ramp_control <= reg_wdata;
				`VRAM_OFS_AM_CTRL: auto_mute_control <= reg_wdata;
				`VRAM_OFS_AM_TIME: auto_mute_time <= reg_wdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			reg_rdata <= 8'h00;
		end else begin
			case (reg_addr)
				`VRAM_OFS_CUR_VOL: reg_rdata <= cur_vol;
				`VRAM_OFS_NORMAL: reg_rdata <= normal_ramp_control;
				`VRAM_OFS_EMERG: reg_rdata <= emergency_ramp_control;
				`VRAM_OFS_AM_CTRL: reg_rdata <= auto_mute_control;
				`VRAM_OFS_AM_TIME: reg_rdata <= auto_mute_time;
				`VRAM_OFS_STATUS: reg_rdata <= {4'h0, state == VRAM_EMERG,
					state != VRAM_IDLE, muted[1], muted[0]};
				default: reg_rdata <= 8'h00;
			endcase
		end
	end

	// ****************************************
	// Emergency input synchronisers
	// ****************************************
	logic [1:0] emerg_meta;
	logic [1:0] emerg_sync;
	logic emerg;

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			emerg_meta <= 2'h0;
			emerg_sync <= 2'h0;
		end else begin
			emerg_meta <= {power_outage, clock_error};
			emerg_sync <= emerg_meta;
		end
	end

	assign emerg = |emerg_sync;

	// ****************************************
	// Data path
	// ****************************************
	vram_pair_t fifo_data;
	logic fifo_valid;
	logic fifo_ready;
	logic tick;

	vram_fifo #(
		.WIDTH(PW),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.mclk(mclk),
		.reset_n(reset_n),
		.in_valid(sample_valid),
		.in_ready(sample_ready),
		.in_data(sample_in),
		.out_valid(fifo_valid),
		.out_ready(fifo_ready),
		.out_data(fifo_data)
	);

	// Each sample that leaves the FIFO marks one sample period.
	assign fifo_ready = !out_valid || out_ready;
	assign tick = fifo_valid && fifo_ready;

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			out_valid <= 1'b0;
			out_word <= '0;
		end else begin
			if (tick) begin
				out_valid <= 1'b1;
				out_word.volume <= cur_vol;
				out_word.mute_left <= muted[0];
				out_word.mute_right <= muted[1];
				out_word.pair <= fifo_data;
			end else if (out_ready) begin
				out_valid <= 1'b0;
			end
		end
	end

	// ****************************************
	// Auto-mute
	// ****************************************
	logic [1:0] ch_zero;
	logic [1:0] qualify;
	logic [1:0] ch_en;
	logic [`VRAM_SIL_CNT_W-1:0] sil_limit [2];

	assign ch_zero[0] = (fifo_data.left == '0);
	assign ch_zero[1] = (fifo_data.right == '0);
	assign ch_en[0] = auto_mute_control[`VRAM_AM_EN_LEFT];
	assign ch_en[1] = auto_mute_control[`VRAM_AM_EN_RIGHT];
	assign sil_limit[0] = sil_len(auto_mute_time[`VRAM_SIL_LEFT]);
	assign sil_limit[1] = sil_len(auto_mute_time[`VRAM_SIL_RIGHT]);

	for (genvar ch = 0; ch < 2; ch++) begin : g_chan
		logic [`VRAM_SIL_CNT_W-1:0] run;

		// The counter saturates at the limit, so a long silence never wraps.
		always_ff @(posedge mclk) begin
			if (!reset_n) begin
				run <= '0;
			end else if (tick) begin
				if (!ch_zero[ch]) begin
					run <= '0;
				end else if (run < sil_limit[ch]) begin
					run <= run + 1'b1;
				end
			end
		end

		assign qualify[ch] = ch_en[ch] && (run >= sil_limit[ch]) && !(tick && !ch_zero[ch]);
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			muted <= 2'h0;
		end else if (auto_mute_control[`VRAM_AM_JOINT]) begin
			muted <= {2{&qualify}};
		end else begin
			muted <= qualify;
		end
	end

	assign mute_left = muted[0];
	assign mute_right = muted[1];

	// ****************************************
	// Volume ramp
	// ****************************************
	logic [7:0] goal;
	logic [1:0] ivl_code;
	logic [1:0] step_code;
	logic [1:0] div;
	logic [7:0] step;

	// Emergency forces the goal to mute regardless of the programmed level.
	assign goal = emerg ? `VRAM_VOL_MUTE : target_volume_level;

	always_comb begin
		next_state = VRAM_IDLE;
		if (cur_vol == goal) begin
			next_state = VRAM_IDLE;
		end else if (emerg) begin
			next_state = VRAM_EMERG;
		end else if (cur_vol < goal) begin
			next_state = VRAM_FALL;
		end else begin
			next_state = VRAM_RISE;
		end
	end

	always_comb begin
		case (state)
			VRAM_RISE: begin
				ivl_code = normal_ramp_control[`VRAM_RISE_IVL];
				step_code = normal_ramp_control[`VRAM_RISE_STEP];
			end
			VRAM_FALL: begin
				ivl_code = normal_ramp_control[`VRAM_FALL_IVL];
				step_code = normal_ramp_control[`VRAM_FALL_STEP];
			end
			VRAM_EMERG: begin
				ivl_code = emergency_ramp_control[`VRAM_FALL_IVL];
				step_code = emergency_ramp_control[`VRAM_FALL_STEP];
			end
			default: begin
				ivl_code = 2'h0;
				step_code = 2'h0;
			end
		endcase
	end

	assign step = step_codes(step_code);

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			state <= VRAM_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			div <= 2'h0;
		end else if (state == VRAM_IDLE || next_state != state) begin
			div <= 2'h0;
		end else if (tick) begin
			div <= (div >= ivl_last(ivl_code)) ? 2'h0 : div + 1'b1;
		end
	end

	// The state lags the goal by one cycle; a goal change in flight is
	// caught by the clamp below, which never steps past the goal.
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			cur_vol <= `VRAM_VOL_0DB;
		end else if (state != VRAM_IDLE && next_state == state) begin
			if (ivl_code == `VRAM_IVL_INSTANT) begin
				cur_vol <= goal;
			end else if (tick && div >= ivl_last(ivl_code)) begin
				if (state == VRAM_RISE) begin
					cur_vol <= (cur_vol - goal > step) ? cur_vol - step : goal;
				end else begin
					cur_vol <= (goal - cur_vol > step) ? cur_vol + step : goal;
				end
			end
		end
	end

	assign current_volume = cur_vol;
endmodule : vram_top

`default_nettype wire

// [testbench/vram_props.sv]
`timescale 1ns/1ps
`include "vram_defines.svh"
`default_nettype none
// ********
// Port checker
// ********
module vram_props import vram_pkg::*; (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic [7:0] target_volume_level,
	input wire logic clock_error,
	input wire logic power_outage,
	input wire logic reg_wr_en,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic sample_valid,
	input wire logic sample_ready,
	input wire vram_pair_t sample_in,
	input wire logic out_valid,
	input wire logic out_ready,
	input wire vram_out_t out_word,
	input wire logic [7:0] current_volume,
	input wire logic mute_left,
	input wire logic mute_right
);
	logic [7:0] nrm;
	logic [7:0] am;
	logic [7:0] tgt_q;
	logic [2:0] quiet;
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			nrm <= `VRAM_RST_NORMAL;
			am <= `VRAM_RST_AM_CTRL;
		end else if (reg_wr_en && reg_addr == `VRAM_OFS_NORMAL) begin
			nrm <= reg_wdata;
		end else if (reg_wr_en && reg_addr == `VRAM_OFS_AM_CTRL) begin
			am <= reg_wdata;
		end
	end
	// Ramp checks wait for calm cycles, because goal and mode reach the ramp a few cycles late.
	always_ff @(posedge mclk) begin
		tgt_q <= target_volume_level;
		if (!reset_n || clock_error || power_outage || reg_wr_en) begin
			quiet <= 3'h0;
		end else if (target_volume_level != tgt_q) begin
			quiet <= 3'h0;
		end else if (quiet != 3'h7) begin
			quiet <= quiet + 3'h1;
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);
	a_reset_volume: assert property (!$past(reset_n) |-> current_volume == `VRAM_VOL_0DB)
		else $error("volume not 0 dB after reset");
	a_fall_limit: assert property (
		quiet == 3'h7 && $past(current_volume) <= target_volume_level
		|-> current_volume <= target_volume_level && current_volume >= $past(current_volume))
		else $error("fall ramp overshoot");
	a_rise_limit: assert property (
		quiet == 3'h7 && $past(current_volume) >= target_volume_level
		|-> current_volume >= target_volume_level && current_volume <= $past(current_volume))
		else $error("rise ramp overshoot");
	a_fall_step: assert property (
		quiet == 3'h7 && nrm[7:6] != `VRAM_IVL_INSTANT && $changed(current_volume)
		&& $past(current_volume) < target_volume_level
		|-> current_volume - $past(current_volume) == (8'h08 >> nrm[5:4])
		|| current_volume == target_volume_level)
		else $error("fall step size wrong");
	// A mute flag obeys the control value that stands just before its edge, so am is not delayed.
	a_joint_pair: assert property (
		am[2:0] == 3'h7 && $rose(mute_left || mute_right) |-> mute_left && mute_right)
		else $error("joint mute split");
	a_left_gate: assert property ($rose(mute_left) |-> am[0])
		else $error("left muted while disabled");
	a_right_gate: assert property ($rose(mute_right) |-> am[1])
		else $error("right muted while disabled");
	a_unmute_left: assert property (
		out_valid && out_word.pair.left != 24'h0 |-> ##[0:2] !mute_left)
		else $error("left mute held on sound");
	c_left_muted: cover property ($rose(mute_left));
	c_full_mute: cover property (current_volume == `VRAM_VOL_MUTE);
	c_stall: cover property (out_valid && !out_ready);
endmodule : vram_props

bind vram_top vram_props u_props (.mclk, .reset_n, .target_volume_level, .clock_error,
	.power_outage, .reg_wr_en, .reg_addr, .reg_wdata, .reg_rdata, .sample_valid, .sample_ready,
	.sample_in, .out_valid, .out_ready, .out_word, .current_volume, .mute_left, .mute_right);
`default_nettype wire

// [testbench/vram_host.sv]
`timescale 1ns/1ps
`default_nettype none
// ********
// Host register port
// ********
module vram_host (
	input wire logic mclk,
	output logic reg_wr_en,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata
);
	initial begin
		reg_wr_en = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	// Write data is scrambled after the strobe so a late capture cannot pass by luck.
	task automatic write(input logic [7:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr_en = 1'b1;
		@(posedge mclk);
		#1;
		reg_wr_en = 1'b0;
		reg_wdata = ~d;
		@(posedge mclk);
		#1;
	endtask : write
	task automatic read(input logic [7:0] a, output logic [7:0] d);
		reg_addr = a;
		@(posedge mclk);
		#1;
		d = reg_rdata;
	endtask : read
endmodule : vram_host
`default_nettype wire

// [testbench/testbench.sv]
`timescale 1ns/1ps
`include "vram_defines.svh"
`default_nettype none
// ********
// Testbench
// ********
module testbench import vram_pkg::*;;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] target_volume_level = 8'h30;
	logic clock_error = 1'b0;
	logic power_outage = 1'b0;
	logic reg_wr_en;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic sample_valid = 1'b0;
	logic sample_ready;
	vram_pair_t sample_in = '0;
	logic out_valid;
	logic out_ready = 1'b1;
	vram_out_t out_word;
	logic [7:0] current_volume;
	logic mute_left;
	logic mute_right;
	int num_errors = 0;
	int total_checks = 0;
	always #5 mclk = ~mclk;
	vram_host host (.mclk, .reg_wr_en, .reg_addr, .reg_wdata, .reg_rdata);
	// A divider of 48 turns silence codes 0 and 1 into exactly 23 and 106 samples.
	vram_top #(.FIFO_DEPTH(8), .SILENCE_DIV(48)) dut (.mclk, .reset_n, .target_volume_level,
		.clock_error, .power_outage, .reg_wr_en, .reg_addr, .reg_wdata, .reg_rdata,
		.sample_valid, .sample_ready, .sample_in, .out_valid, .out_ready, .out_word,
		.current_volume, .mute_left, .mute_right);
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : cyc
	task automatic chk(input logic ok, input string msg);
		total_checks++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("MISMATCH at %0t: %s", $time, msg);
		end
	endtask : chk
	task automatic conclude;
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : conclude
	task automatic send(input logic [23:0] l, input logic [23:0] r);
		sample_in = {l, r};
		sample_valid = 1'b1;
		while (sample_ready !== 1'b1) cyc(1);
		cyc(1);
		sample_valid = 1'b0;
		sample_in = ~sample_in;
		cyc(4);
	endtask : send
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		host.read(a, d);
		chk(d === exp, "register readback");
	endtask : rd
	task automatic go(input logic [7:0] v);
		host.write(`VRAM_OFS_NORMAL, 8'hFF);
		target_volume_level = v;
		cyc(6);
		chk(current_volume === v, "instant volume jump");
	endtask : go
	task automatic ticks(input int n, input int dv, input int st, input int a, input int b);
		int x;
		for (int k = 1; k <= n; k++) begin
			send(24'h1, 24'h1);
			x = (a < b) ? a + (k / dv) * st : a - (k / dv) * st;
			if ((a < b) ? x > b : x < b) x = b;
			chk(current_volume === 8'(x), "ramp volume");
		end
	endtask : ticks
	task automatic t_regs;
		rd(`VRAM_OFS_NORMAL, 8'h33);
		rd(`VRAM_OFS_EMERG, 8'h30);
		rd(`VRAM_OFS_AM_CTRL, 8'h07);
		rd(`VRAM_OFS_AM_TIME, 8'h00);
		rd(8'h60, 8'h00);
		rd(`VRAM_OFS_CUR_VOL, 8'h30);
		chk(current_volume === 8'h30, "reset volume");
		host.write(`VRAM_OFS_EMERG, 8'h5A);
		rd(`VRAM_OFS_EMERG, 8'h5A);
		$display("t_regs done");
	endtask : t_regs
	task automatic t_ramps;
		int iv;
		for (int i = 0; i < 4; i++) begin
			iv = (i == 3) ? 0 : i;
			go(8'h3B);
			host.write(`VRAM_OFS_NORMAL, {4'hF, 2'(iv), 2'(i)});
			target_volume_level = 8'h30;
			cyc(2);
			ticks(24, 1 << iv, 8 >> i, 8'h3B, 8'h30);
			go(8'h20);
			host.write(`VRAM_OFS_NORMAL, {2'(iv), 2'(i), 4'hF});
			target_volume_level = 8'h2B;
			cyc(2);
			ticks(24, 1 << iv, 8 >> i, 8'h20, 8'h2B);
		end
		$display("t_ramps done");
	endtask : t_ramps
	task automatic t_emerg;
		go(8'h30);
		host.write(`VRAM_OFS_EMERG, 8'h40);
		clock_error = 1'b1;
		cyc(6);
		ticks(6, 2, 8, 8'h30, 8'hFF);
		rd(`VRAM_OFS_STATUS, 8'h0C);
		clock_error = 1'b0;
		cyc(8);
		chk(current_volume === 8'h30, "restore after clock error");
		host.write(`VRAM_OFS_EMERG, 8'hC0);
		power_outage = 1'b1;
		cyc(8);
		chk(current_volume === 8'hFF, "instant emergency mute");
		power_outage = 1'b0;
		cyc(8);
		$display("t_emerg done");
	endtask : t_emerg
	task automatic silence(input logic [7:0] ctl, input int tl, input int tr);
		send(24'h1, 24'h1);
		host.write(`VRAM_OFS_AM_CTRL, ctl);
		for (int k = 1; k <= 110; k++) begin
			send(24'h0, 24'h0);
			chk(mute_left === 1'(k >= tl) && mute_right === 1'(k >= tr), "mute flags");
		end
	endtask : silence
	task automatic t_silence;
		host.write(`VRAM_OFS_AM_TIME, 8'h10);
		silence(8'h03, 106, 23);
		send(24'h5, 24'h0);
		chk(mute_left === 1'b0 && mute_right === 1'b1, "unmute on sound");
		rd(`VRAM_OFS_STATUS, 8'h02);
		silence(8'h07, 106, 106);
		silence(8'h02, 999, 23);
		silence(8'h01, 106, 999);
		$display("t_silence done");
	endtask : t_silence
	task automatic t_fifo;
		int n;
		n = 0;
		out_ready = 1'b0;
		sample_valid = 1'b1;
		repeat (14) begin
			sample_in = {24'(n + 1), 24'h1};
			if (sample_ready === 1'b1) n++;
			cyc(1);
		end
		sample_valid = 1'b0;
		// Eight words wait in the FIFO and one more in the output register.
		chk(n == 9 && sample_ready === 1'b0, "fifo refuses when full");
		out_ready = 1'b1;
		for (int i = 1; i <= n; i++) begin
			while (out_valid !== 1'b1) cyc(1);
			chk(out_word.pair.left === 24'(i), "fifo order");
			chk(out_word.volume === `VRAM_VOL_0DB, "word volume");
			// Only the first word left while the left channel was still auto-muted.
			chk(out_word.mute_left === 1'(i == 1), "word left mute");
			chk(out_word.mute_right === 1'b0, "word right mute");
			cyc(1);
		end
		$display("t_fifo done");
	endtask : t_fifo
	initial begin
		cyc(3);
		reset_n = 1'b1;
		t_regs();
		t_ramps();
		t_emerg();
		t_silence();
		t_fifo();
		conclude();
	end
	initial begin
		#400us;
		num_errors++;
		$display("MISMATCH at %0t: watchdog expired", $time);
		conclude();
	end
endmodule : testbench
`default_nettype wire
